//--- rtl/irsq_consts.svh
// Timing counts, field positions and reset values of the readout sequencer
// Operation
// - Pixel valid five clocks after line sync
// - Row blanking is 35 times row granularity
// - Four reset levels usable in multi-slope
// - Global: enable high at exposure begin: reduced reset
// - Global: exposure begin clears integration time counter
// - Rolling: exposure timer pulses at reset sync
// - Rolling: frame begin loads read row pointer
// - Rolling: reset sync after integration lines
// - Column load overrides sync, loads column pointer
// - Column load held over two rising edges
// - Frame begin loads new row pointer
// - Frame begin triggers amplifier calibration
// - Reset clears every configuration register
// - Readout active from sync to pixel limit
// - Upload word: address 15:12, data 11:0
`ifndef IRSQ_CONSTS_SVH
`define IRSQ_CONSTS_SVH
`define IRSQ_CLK_PERIOD_PS   5000
`define IRSQ_VALID_LAT       5
`define IRSQ_BLANK_MULT      35
`define IRSQ_STABLE_MULT     5
`define IRSQ_ROW_GRAN_BASE   4
`define IRSQ_SS_GRAN_BASE    32
`define IRSQ_ADDR_MSB        15
`define IRSQ_ADDR_LSB        12
`define IRSQ_DATA_MSB        11
`define IRSQ_A_CTRL          4'h0
`define IRSQ_A_NPIX          4'h1
`define IRSQ_A_NLINE         4'h2
`define IRSQ_A_INT           4'h3
`define IRSQ_A_COLPTR        4'h4
`define IRSQ_A_RDROW         4'h5
`define IRSQ_A_RSTROW        4'h6
`define IRSQ_C_ROLL          0
`define IRSQ_C_RGRAN         1
`define IRSQ_C_SGRAN         3
`define IRSQ_C_LVLSEL        5
`define IRSQ_C_LVLEN         7
`define IRSQ_REG_RST         12'h000
`endif

//--- rtl/irsq_pkg.sv
// Types of the readout sequencer
package irsq_pkg;
	typedef enum logic [1:0] {IRSQ_IDLE, IRSQ_BLANK, IRSQ_LAT, IRSQ_PIX} irsq_xst_t;
endpackage

//--- rtl/irsq_sequencer.sv
// Image sensor readout sequencer: row/pixel timing, shutter and windowing
`timescale 1ns/1ps
`include "irsq_consts.svh"
module irsq_sequencer #(
	parameter int W = 12
) (
	input  wire logic          CLK,          // Pixel clock
	input  wire logic          RST_N,        // Global reset, active low
	input  wire logic          UP_WR,        // Upload write strobe
	input  wire logic [15:0]   UP_WORD,      // Upload word: address and data
	input  wire logic          LINE_START,   // Line clock pulse
	input  wire logic          FRAME_BEGIN,  // Frame begin pulse
	input  wire logic          COL_LOAD,     // Column pointer load pulse
	input  wire logic          EXP_BEGIN,    // Exposure begin pulse
	input  wire logic          EXP_END,      // Exposure end pulse
	output logic               READOUT_ACT,  // Readout active
	output logic               PIX_VALID,    // Pixel on analog output valid
	output logic [W-1:0]       PIX_COL,      // Column addressed on output
	output logic [W-1:0]       READ_ROW,     // Read row shift register
	output logic [W-1:0]       RESET_ROW,    // Reset row shift register
	output logic               EXP_TIMER,    // Exposure timer pulse
	output logic               RST_LVL_ACT,  // Reduced-voltage pixel reset pulse
	output logic [1:0]         RST_LVL_SEL,  // Reset level used
	output logic               AMP_CAL,      // Amplifier calibration pulse
	output logic [W-1:0]       INT_COUNT     // Integration time counter
);
	// Pin synchronisers: two flops per strobe, a third flop only for edge detection
	// Strobe order in the vector: line, frame, column load, begin, end
	logic [4:0]  pin_w;
	logic [4:0]  s1_r, s2_r, s3_r;
	logic        up_s1_r, up_s2_r;
	logic [15:0] w_s1_r, w_s2_r;
	assign pin_w = {EXP_END, EXP_BEGIN, COL_LOAD, FRAME_BEGIN, LINE_START};
	for (genvar i = 0; i < 5; i++) begin : g_sync
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N) begin
				s1_r[i] <= 1'b0;
				s2_r[i] <= 1'b0;
				s3_r[i] <= 1'b0;
			end else begin
				s1_r[i] <= pin_w[i];
				s2_r[i] <= s1_r[i];
				s3_r[i] <= s2_r[i];
			end
		end
	end
	// Upload strobe synchroniser
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			up_s1_r <= 1'b0;
			up_s2_r <= 1'b0;
		end else begin
			up_s1_r <= UP_WR;
			up_s2_r <= up_s1_r;
		end
	end
	// The word is held by the controller while its strobe stands, so two flops
	// per bit suffice: it is only read on the synchronised strobe edge
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			w_s1_r <= 16'h0000;
			w_s2_r <= 16'h0000;
		end else begin
			w_s1_r <= UP_WORD;
			w_s2_r <= w_s1_r;
		end
	end
	// Rising edges of the synchronised strobes; each lasts one clock
	logic [4:0] rise;
	assign rise = s2_r & ~s3_r;
	wire line_p  = rise[0];
	wire frame_p = rise[1];
	wire col_p   = rise[2];
	wire exb_p   = rise[3];
	wire exe_p   = rise[4];
	// Register upload: one word per synchronised strobe rising edge
	logic         up_d_r;
	wire          up_p = up_s2_r & ~up_d_r;
	wire [3:0]    up_a = w_s2_r[`IRSQ_ADDR_MSB:`IRSQ_ADDR_LSB];
	wire [11:0]   up_d = w_s2_r[`IRSQ_DATA_MSB:0];
	logic [11:0]  ctrl_r, npix_r, nline_r, intl_r, colptr_r, rdrow_r, rstrow_r;
	// One write enable per mapped address; other addresses write nothing
	wire          we_ctrl   = up_p && (up_a == `IRSQ_A_CTRL);
	wire          we_npix   = up_p && (up_a == `IRSQ_A_NPIX);
	wire          we_nline  = up_p && (up_a == `IRSQ_A_NLINE);
	wire          we_int    = up_p && (up_a == `IRSQ_A_INT);
	wire          we_colptr = up_p && (up_a == `IRSQ_A_COLPTR);
	wire          we_rdrow  = up_p && (up_a == `IRSQ_A_RDROW);
	wire          we_rstrow = up_p && (up_a == `IRSQ_A_RSTROW);
	// Delayed strobe copy for edge detection
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			up_d_r <= 1'b0;
		else
			up_d_r <= up_s2_r;
	end
	// Control word: rolling mode, granularities, level select and enable
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			ctrl_r <= `IRSQ_REG_RST;
		else if (we_ctrl)
			ctrl_r <= up_d;
	end
	// Pixel and line count limits
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			npix_r <= `IRSQ_REG_RST;
		else if (we_npix)
			npix_r <= up_d;
	end
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			nline_r <= `IRSQ_REG_RST;
		else if (we_nline)
			nline_r <= up_d;
	end
	// Rolling-shutter integration length in lines
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			intl_r <= `IRSQ_REG_RST;
		else if (we_int)
			intl_r <= up_d;
	end
	// Window pointers: column, read row and reset row
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			colptr_r <= `IRSQ_REG_RST;
		else if (we_colptr)
			colptr_r <= up_d;
	end
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			rdrow_r <= `IRSQ_REG_RST;
		else if (we_rdrow)
			rdrow_r <= up_d;
	end
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			rstrow_r <= `IRSQ_REG_RST;
		else if (we_rstrow)
			rstrow_r <= up_d;
	end
	wire       roll   = ctrl_r[`IRSQ_C_ROLL];
	wire [1:0] rgran  = ctrl_r[`IRSQ_C_RGRAN +: 2];
	wire [1:0] lvlsel = ctrl_r[`IRSQ_C_LVLSEL +: 2];
	wire       lvlen  = ctrl_r[`IRSQ_C_LVLEN];
	// Row blanking length: 35 x (4 << code)
	wire [15:0] blank_len = 16'(`IRSQ_BLANK_MULT * (`IRSQ_ROW_GRAN_BASE << rgran));
	// Column sequencer
	irsq_pkg::irsq_xst_t xst_r, xst_nxt;
	logic [15:0] xcnt_r, xcnt_nxt;
	logic [W-1:0] col_r, col_nxt;
	logic [W-1:0] pcnt_r, pcnt_nxt;
	wire  sync_int = (xst_r == irsq_pkg::IRSQ_BLANK) && (xcnt_r == blank_len - 16'h0001);
	wire  xsync    = sync_int | col_p;
	always_comb begin
		xst_nxt = xst_r;
		xcnt_nxt = xcnt_r + 16'h0001;
		col_nxt = col_r;
		pcnt_nxt = pcnt_r;
		case (xst_r)
			irsq_pkg::IRSQ_IDLE: begin
				if (line_p) begin
					xst_nxt = irsq_pkg::IRSQ_BLANK;
					xcnt_nxt = 16'h0000;
				end
			end
			irsq_pkg::IRSQ_BLANK: ;
			irsq_pkg::IRSQ_LAT: begin
				if (xcnt_r == 16'(`IRSQ_VALID_LAT - 1)) begin
					xst_nxt = irsq_pkg::IRSQ_PIX;
					pcnt_nxt = '0;
				end
			end
			irsq_pkg::IRSQ_PIX: begin
				col_nxt = col_r + W'(1);
				pcnt_nxt = pcnt_r + W'(1);
				if (pcnt_r + W'(1) >= W'(npix_r))
					xst_nxt = irsq_pkg::IRSQ_IDLE;
			end
			default: xst_nxt = irsq_pkg::IRSQ_IDLE;
		endcase
		if (xsync) begin
			xst_nxt = irsq_pkg::IRSQ_LAT;
			xcnt_nxt = 16'h0000;
			col_nxt = col_p ? W'(colptr_r) : col_r;
		end
	end
	// State and cycle counter of the column sequencer
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			xst_r <= irsq_pkg::IRSQ_IDLE;
		else
			xst_r <= xst_nxt;
	end
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			xcnt_r <= 16'h0000;
		else
			xcnt_r <= xcnt_nxt;
	end
	// Column address and pixel count within the row
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			col_r <= '0;
		else
			col_r <= col_nxt;
	end
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			pcnt_r <= '0;
		else
			pcnt_r <= pcnt_nxt;
	end
	// Row pointers, line counting, rolling shutter
	logic [W-1:0] lcnt_r;
	wire reset_sync = roll && line_p && (lcnt_r + W'(1) == W'(intl_r));
	// Shutter: integration counter and reduced-voltage reset
	// Exposure begin only acts in global mode; a rolling frame ignores it
	wire gs_begin = exb_p && !roll;
	// Synchronised exposure end level: the counter freezes while it stands
	wire exe_hold = s2_r[4];
	// Line counter restarts on every frame begin and counts line pulses
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			lcnt_r <= '0;
		else if (frame_p)
			lcnt_r <= '0;
		else if (line_p)
			lcnt_r <= lcnt_r + W'(1);
	end
	// Read row loads on frame begin and steps once per line
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			READ_ROW <= '0;
		else if (frame_p)
			READ_ROW <= W'(rdrow_r);
		else if (line_p)
			READ_ROW <= READ_ROW + W'(1);
	end
	// The reset row only advances in rolling mode, where it leads the read row
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			RESET_ROW <= '0;
		else if (reset_sync)
			RESET_ROW <= W'(rstrow_r);
		else if (line_p && roll)
			RESET_ROW <= RESET_ROW + W'(1);
	end
	// One-clock pulses: rolling reset sync and amplifier calibration
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			EXP_TIMER <= 1'b0;
			AMP_CAL <= 1'b0;
		end else begin
			EXP_TIMER <= reset_sync;
			AMP_CAL <= frame_p;
		end
	end
	// Every global-mode exposure begin restarts the count, intermediate slopes included;
	// otherwise the counter runs, holds while exposure end stands, and wraps
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			INT_COUNT <= '0;
		else if (gs_begin)
			INT_COUNT <= '0;
		else if (!exe_hold)
			INT_COUNT <= INT_COUNT + W'(1);
	end
	// Reduced-voltage reset pulse, only with the level enable set
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			RST_LVL_ACT <= 1'b0;
		else
			RST_LVL_ACT <= gs_begin && lvlen;
	end
	// Level is taken at exposure begin, so later uploads cannot disturb a reset
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			RST_LVL_SEL <= 2'h0;
		else if (gs_begin)
			RST_LVL_SEL <= lvlen ? lvlsel : 2'h0;
	end
	// Registered outputs, decoded from the next state so that they line up with it
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			READOUT_ACT <= 1'b0;
		else
			READOUT_ACT <= (xst_nxt == irsq_pkg::IRSQ_LAT) || (xst_nxt == irsq_pkg::IRSQ_PIX);
	end
	// Pixel valid follows the pixel phase, five clocks after the sync
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			PIX_VALID <= 1'b0;
		else
			PIX_VALID <= xst_nxt == irsq_pkg::IRSQ_PIX;
	end
	// Column follows the column next value so that it lines up with pixel valid
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			PIX_COL <= '0;
		else
			PIX_COL <= col_nxt;
	end
endmodule

//--- tb/irsq_sequencer_sva.sv
// Port checks of the readout sequencer
`timescale 1ns/1ps
module irsq_sequencer_sva #(
	parameter int W = 12
) (
	input wire logic         CLK,         // Clock
	input wire logic         RST_N,       // Reset
	input wire logic         FRAME_BEGIN, // Frame
	input wire logic         READOUT_ACT, // Readout
	input wire logic         PIX_VALID,   // Valid
	input wire logic         EXP_TIMER,   // Timer
	input wire logic         RST_LVL_ACT, // Level
	input wire logic         AMP_CAL,     // Cal
	input wire logic [W-1:0] INT_COUNT,   // Count
	input wire logic [W-1:0] READ_ROW     // Row
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	AST_RST: assert property ($rose(RST_N) |-> !PIX_VALID && READ_ROW == '0)
		else $error("outputs not clear");
	AST_ACT: assert property (PIX_VALID |-> READOUT_ACT)
		else $error("valid outside readout");
	AST_LAT: assert property ($rose(READOUT_ACT) |-> !PIX_VALID [*4])
		else $error("pixel too early");
	AST_END: assert property ($fell(READOUT_ACT) |-> $past(PIX_VALID))
		else $error("readout ended without pixels");
	AST_TMR: assert property (EXP_TIMER |=> !EXP_TIMER)
		else $error("timer pulse too long");
	AST_CAL: assert property ($rose(FRAME_BEGIN) |-> ##[1:8] AMP_CAL)
		else $error("no calibration");
	AST_CAL1: assert property (AMP_CAL |=> !AMP_CAL)
		else $error("calibration too long");
	AST_INT: assert property (INT_COUNT < $past(INT_COUNT) |-> INT_COUNT == '0)
		else $error("counter not cleared");
	AST_LVL: assert property (RST_LVL_ACT |=> !RST_LVL_ACT)
		else $error("level reset too long");
	cover property ($fell(PIX_VALID));
	cover property (EXP_TIMER);
	cover property (RST_LVL_ACT);
endmodule

//--- tb/irsq_ctl_model.sv
// Controller model driving the sequencer strobes
`timescale 1ns/1ps
module irsq_ctl_model (
	input  wire logic  CLK,           // Clock
	output logic [4:0] STRB = 5'h00   // Line, frame, column, begin, end; low from start
);
	logic [4:0] req = 5'h00;
	int         hold [5] = '{default: 0};
	// Strobes change on the falling edge and stand over four rising edges
	always @(negedge CLK) begin
		for (int k = 0; k < 5; k++) begin
			if (req[k]) begin
				STRB[k] <= 1'b1;
				hold[k] <= 3;
			end else if (hold[k] > 0)
				hold[k] <= hold[k] - 1;
			else
				STRB[k] <= 1'b0;
		end
	end
	task automatic pulse(input int k);
		@(posedge CLK) #1;
		req[k] = 1'b1;
		@(posedge CLK) #1;
		req[k] = 1'b0;
		repeat (4) @(posedge CLK);
	endtask
endmodule

//--- tb/irsq_sequencer_bench.sv
// Self-checking bench of the readout sequencer
`timescale 1ns/1ps
module irsq_sequencer_bench;
	logic clk = 1'b0, rst_n = 1'b0, up_wr = 1'b0, ract, pv, et, rla, cal;
	logic [15:0] up_word = 16'h0000;
	logic [4:0] strb;
	logic [1:0] rls;
	logic [11:0] col, rrow, srow, icnt;
	wire [3:0] mon = {cal, et, pv, ract};
	int mismatches = 0, n_checks = 0, cyc = 0, ncal = 0, net = 0, nla = 0, npv = 0, d, d0, p;
	always #2.5 clk = ~clk;
	irsq_sequencer irsq_sequencer_inst (.CLK(clk), .RST_N(rst_n), .UP_WR(up_wr),
		.UP_WORD(up_word), .LINE_START(strb[0]), .FRAME_BEGIN(strb[1]), .COL_LOAD(strb[2]),
		.EXP_BEGIN(strb[3]), .EXP_END(strb[4]), .READOUT_ACT(ract), .PIX_VALID(pv),
		.PIX_COL(col), .READ_ROW(rrow), .RESET_ROW(srow), .EXP_TIMER(et), .RST_LVL_ACT(rla),
		.RST_LVL_SEL(rls), .AMP_CAL(cal), .INT_COUNT(icnt));
	irsq_ctl_model irsq_ctl_model_inst (.CLK(clk), .STRB(strb));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		ncal <= ncal + int'(cal);
		net <= net + int'(et);
		nla <= nla + int'(rla);
		npv <= npv + int'(pv);
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [11:0] v);
		@(posedge clk) #1;
		up_word = {a, v};
		up_wr = 1'b1;
		repeat (4) @(posedge clk);
		#1 up_wr = 1'b0;
		repeat (45) @(posedge clk);
	endtask
	task automatic wait_hi(input int k, input logic v);
		int n = 0;
		while (mon[k] !== v && n < 3000) begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	task automatic line(output int t);
		irsq_ctl_model_inst.pulse(0);
		t = cyc;
		wait_hi(0, 1'b1);
		t = cyc - t;
		wait_hi(0, 1'b0);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		chk({7'h00, ract, pv, et, rla, cal}, 12'h000);
		chk(icnt, 12'h000);
		wr(4'h1, 12'h008);
		for (int g = 0; g < 4; g++) begin
			wr(4'h0, 12'(g << 1));
			p = npv;
			line(d);
			if (g == 0)
				d0 = d;
			chk(12'(d - d0), 12'(35 * ((4 << g) - 4)));
			chk(12'(npv - p), 12'h008);
		end
		wr(4'h4, 12'h024);
		irsq_ctl_model_inst.pulse(2);
		wait_hi(1, 1'b1);
		chk(col, 12'h024);
		wait_hi(0, 1'b0);
		wr(4'h5, 12'h00a);
		wr(4'h6, 12'h00a);
		p = ncal;
		irsq_ctl_model_inst.pulse(1);
		repeat (8) @(posedge clk);
		#1 chk(12'(ncal - p), 12'h001);
		chk(rrow, 12'h00a);
		p = nla;
		for (int k = 1; k < 4; k++) begin
			wr(4'h0, 12'(k << 5 | 128));
			irsq_ctl_model_inst.pulse(3);
			repeat (8) @(posedge clk);
			#1 chk(12'(rls), 12'(k));
			chk(12'(icnt < 12), 12'h001);
			repeat (160) @(posedge clk);
		end
		chk(12'(nla - p), 12'h003);
		wr(4'h0, 12'h000);
		irsq_ctl_model_inst.pulse(4);
		wr(4'h3, 12'h002);
		wr(4'h2, 12'h004);
		wr(4'h0, 12'h001);
		irsq_ctl_model_inst.pulse(1);
		p = net;
		for (int l = 1; l < 4; l++) begin
			line(d);
			chk(12'(net - p), 12'(l >= 2));
		end
		chk(srow, 12'h00b);
		stop_test();
	end
endmodule
bind irsq_sequencer irsq_sequencer_sva #(.W(W)) irsq_sequencer_sva_inst (.CLK, .RST_N,
	.FRAME_BEGIN, .READOUT_ACT, .PIX_VALID, .EXP_TIMER, .RST_LVL_ACT, .AMP_CAL, .INT_COUNT,
	.READ_ROW);
